/* tcm_channel.sv */
// tcm_channel: mode register, trigger decode and start control of one channel
//
// The implementer's own choice: the APB register port.

// Operation
// RQ1 - code 00 falling, 01 rising edge
// RQ2 - code 10: start falling, capture rising
// RQ3 - code 11: start rising, capture falling
// RQ4 - software uses 10 for both edges
// RQ5 - bit 11 reads zero where absent
// RQ6 - mode 000 interval timer, counts down
// RQ7 - mode 010 capture, counts up
// RQ8 - mode 011 event counter, counts down
// RQ9 - mode 100 one-count, counts down
// RQ10 - mode 110 capture one-count, counts up
// RQ11 - software avoids prohibited mode codes
// RQ12 - low bit 0: no start interrupt
// RQ13 - interval/capture low bit 1: start interrupt
// RQ14 - one-count bit 0: ignore retrigger
// RQ15 - one-count bit 1: accept retrigger, interrupt
// RQ16 - software restart reinitialises, no interrupt
// RQ17 - one-count start drives no interrupt
// RQ18 - capture one-count: no start irq, no retrigger
// RQ19 - sixteen-bit register, resets to zero
// RQ20 - fixed field layout, reserved bits zero
// RQ21 - trigger 010 uses both edges
// RQ22 - input synchronised, single-cycle edge pulses
module tcm_channel #(
  parameter int CHAN = 0
) (
  // apb slave
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [tcm_pkg::TCM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // pin and neighbour inputs
  input  wire logic                           channel_input_pin,
  input  wire logic                           master_irq,
  input  wire logic                           count_done,
  // triggers to the counter datapath
  output tcm_pkg::tcm_trig_t                  trig,
  output logic                                count_up,
  output logic                                counting
);
  import tcm_pkg::*;

  // ***********************************************************
  // address decode
  // ***********************************************************
  localparam logic [19:0] CH_OFF   = 20'(CHAN) * TCM_CHAN_STRIDE;
  localparam logic [19:0] MODE_IDX = TCM_MODE_IDX0 + CH_OFF;
  localparam logic [19:0] CTRL_IDX = TCM_CTRL_IDX0 + CH_OFF;
  localparam logic [19:0] STAT_IDX = TCM_STAT_IDX0 + CH_OFF;
  localparam logic [TCM_ADDR_W-1:0] MODE_ADDR =
    TCM_ADDR_W'({MODE_IDX, 2'b00});
  localparam logic [TCM_ADDR_W-1:0] CTRL_ADDR =
    TCM_ADDR_W'({CTRL_IDX, 2'b00});
  localparam logic [TCM_ADDR_W-1:0] STAT_ADDR =
    TCM_ADDR_W'({STAT_IDX, 2'b00});
  // bit 11 only writable on channels owning a master/split bit
  localparam logic [15:0] WMSK = TCM_BIT11_CH[CHAN] ? TCM_MODE_WMSK
                                 : (TCM_MODE_WMSK & ~TCM_BIT11_MSK);

  logic        sel_mode;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        mapped;
  logic        access;
  logic        wr_fire;
  logic [31:0] rd_val;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [15:0] mode_raw_r;
  tcm_mode_t   mode;

  assign sel_mode = (paddr == MODE_ADDR);
  assign sel_ctrl = (paddr == CTRL_ADDR);
  assign sel_stat = (paddr == STAT_ADDR);
  assign mapped   = sel_mode | sel_ctrl | sel_stat;
  assign access   = psel & penable;
  // write lands at the edge where the master sees pready high
  assign wr_fire  = access & pready_r & pwrite;
  assign mode     = tcm_mode_t'(mode_raw_r);

  // ***********************************************************
  // synchroniser and edge detect
  // ***********************************************************
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic rise;
  logic fall;

  // first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= channel_input_pin; // see RQ22
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign rise = pin_sync_r & ~pin_prev_r; // see RQ22
  assign fall = ~pin_sync_r & pin_prev_r; // see RQ22

  // ***********************************************************
  // edge and trigger source selection
  // ***********************************************************
  logic edge_start;
  logic edge_cap;
  logic ext_start;
  logic ext_cap;

  // pick the valid edge for start and capture
  always_comb begin
    edge_start = 1'b0;
    edge_cap   = 1'b0;
    case (mode.edge_select)
      TCM_EDGE_FALL: begin
        edge_start = fall; // see RQ1
        edge_cap   = fall;
      end
      TCM_EDGE_RISE: begin
        edge_start = rise; // see RQ1
        edge_cap   = rise;
      end
      TCM_EDGE_LOW: begin
        edge_start = fall; // see RQ2
        edge_cap   = rise;
      end
      TCM_EDGE_HIGH: begin
        edge_start = rise; // see RQ3
        edge_cap   = fall;
      end
      default: begin
        edge_start = 1'b0;
        edge_cap   = 1'b0;
      end
    endcase
  end

  // source field picks software only, pin, both edges or master
  always_comb begin
    ext_start = 1'b0;
    ext_cap   = 1'b0;
    if (mode.trigger_source[2]) begin
      ext_start = master_irq;
    end else begin
      case (mode.trigger_source)
        TCM_TRIG_SW: begin
          ext_start = 1'b0;
          ext_cap   = 1'b0;
        end
        TCM_TRIG_EDGE: begin
          ext_start = edge_start;
          ext_cap   = edge_cap;
        end
        TCM_TRIG_BOTH: begin
          ext_start = rise | fall; // see RQ21
          ext_cap   = rise | fall; // see RQ21
        end
        default: begin
          ext_start = 1'b0;
          ext_cap   = 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************
  // mode decode
  // ***********************************************************
  logic legal;
  logic up_nxt;
  logic one_shot;   // counting ends on its own
  logic cap_mode;
  logic start_irq;  // interrupt and output change at count start
  logic retrig_ok;  // start accepted while counting

  always_comb begin
    legal     = 1'b1;
    up_nxt    = 1'b0;
    one_shot  = 1'b0;
    cap_mode  = 1'b0;
    start_irq = 1'b0;
    retrig_ok = 1'b0;
    case (mode.op_mode)
      TCM_MD_INTERVAL: begin
        start_irq = mode.start_behaviour_bit; // see RQ6, RQ12, RQ13
      end
      TCM_MD_CAPTURE: begin
        up_nxt    = 1'b1; // see RQ7
        cap_mode  = 1'b1;
        start_irq = mode.start_behaviour_bit; // see RQ12, RQ13
      end
      TCM_MD_EVENT: begin
        start_irq = 1'b0; // see RQ8, RQ12
      end
      TCM_MD_ONECOUNT: begin
        one_shot  = 1'b1; // see RQ9, RQ17
        retrig_ok = mode.start_behaviour_bit; // see RQ14, RQ15
      end
      TCM_MD_CAPONE: begin
        up_nxt    = 1'b1; // see RQ10
        one_shot  = 1'b1;
        cap_mode  = 1'b1;
        legal     = ~mode.start_behaviour_bit; // see RQ18
      end
      default: begin
        legal = 1'b0; // prohibited codes do nothing
      end
    endcase
  end

  // ***********************************************************
  // start control
  // ***********************************************************
  logic      sw_start;
  logic      sw_stop;
  logic      counting_r;
  logic      count_up_r;
  tcm_trig_t trig_r;
  tcm_trig_t trig_nxt;
  logic      counting_nxt;

  assign sw_start = wr_fire & sel_ctrl & pwdata[TCM_CTRL_START];
  assign sw_stop  = wr_fire & sel_ctrl & pwdata[TCM_CTRL_STOP];

  // a software restart always reloads; the pin only where allowed
  always_comb begin
    trig_nxt     = TCM_TRIG_IDLE;
    counting_nxt = counting_r;
    if (!legal) begin
      counting_nxt = 1'b0;
    end else if (!counting_r) begin
      if (sw_start || ext_start) begin
        trig_nxt.reload = 1'b1;
        trig_nxt.irq    = start_irq; // see RQ12, RQ13, RQ17, RQ18
        trig_nxt.toggle = start_irq; // see RQ12, RQ13, RQ17
        counting_nxt    = 1'b1;
      end
    end else begin
      if (sw_start) begin
        trig_nxt.reload = 1'b1; // see RQ16
      end else if (ext_start && retrig_ok) begin
        trig_nxt.reload = 1'b1; // see RQ15
        trig_nxt.irq    = 1'b1; // see RQ15
      end else if (ext_cap && cap_mode) begin
        trig_nxt.capture = 1'b1;
        if (one_shot) begin
          counting_nxt = 1'b0; // width measured, wait next start
        end
      end else if (count_done && one_shot) begin
        counting_nxt = 1'b0; // see RQ14, RQ18
      end
    end
    if (sw_stop) begin
      counting_nxt   = 1'b0;
      trig_nxt       = TCM_TRIG_IDLE;
    end
  end

  // counting state and trigger pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counting_r <= 1'b0;
      trig_r     <= TCM_TRIG_IDLE;
      count_up_r <= 1'b0;
    end else begin
      counting_r <= counting_nxt;
      trig_r     <= trig_nxt;
      count_up_r <= up_nxt; // see RQ6, RQ7, RQ8, RQ9, RQ10
    end
  end

  // ***********************************************************
  // register file and apb answer
  // ***********************************************************
  // mode register; reserved and absent bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_raw_r <= TCM_MODE_RST; // see RQ19
    end else if (wr_fire && sel_mode) begin
      mode_raw_r <= pwdata[15:0] & WMSK; // see RQ5, RQ20
    end
  end

  // read mux, upper half reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (sel_mode) begin
      rd_val[15:0] = mode_raw_r;
    end else if (sel_stat) begin
      rd_val[TCM_ST_COUNT] = counting_r;
      rd_val[TCM_ST_UP]    = count_up_r;
      rd_val[TCM_ST_LEGAL] = legal;
      rd_val[TCM_ST_PIN]   = pin_sync_r;
    end
  end

  // one wait state so every output is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access && !pready_r && !pwrite) begin
        prdata_r <= rd_val;
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign trig     = trig_r;
  assign count_up = count_up_r;
  assign counting = counting_r;

endmodule // tcm_channel

/* tcm_pkg.sv */
// tcm_pkg: constants and types for the timer channel mode control block
package tcm_pkg;

  // ***********************************************************
  // register map (indices; byte address is four times index)
  // ***********************************************************
  localparam logic [19:0] TCM_MODE_IDX0   = 20'hf0190; // channel 0 mode
  localparam logic [19:0] TCM_MODE_IDX7   = 20'hf019e; // channel 7 mode
  localparam logic [19:0] TCM_CHAN_STRIDE = 20'h00002; // two-word step
  localparam logic [19:0] TCM_CTRL_IDX0   = 20'hf01c0; // start/stop
  localparam logic [19:0] TCM_STAT_IDX0   = 20'hf01d0; // channel state
  localparam int          TCM_ADDR_W      = 24;

  // ***********************************************************
  // mode register layout and reset
  // ***********************************************************
  typedef struct packed {
    logic [1:0] clock_select_field;  // 15:14
    logic       zero13;              // 13
    logic       count_clock_source;  // 12
    logic       chan_bit11;          // 11, master or split select
    logic [2:0] trigger_source;      // 10:8
    logic [1:0] edge_select;         // 7:6
    logic [1:0] zero5_4;             // 5:4
    logic [2:0] op_mode;             // 3:1
    logic       start_behaviour_bit; // 0
  } tcm_mode_t;

  localparam logic [15:0] TCM_MODE_RST  = 16'h0000;
  localparam logic [15:0] TCM_MODE_WMSK = 16'hdfcf; // 13, 5, 4 read zero
  localparam logic [15:0] TCM_BIT11_MSK = 16'h0800;
  // channels 1,2,3,4,6 carry a master or split bit
  localparam logic [7:0]  TCM_BIT11_CH  = 8'h5e;

  // ***********************************************************
  // field encodings
  // ***********************************************************
  localparam logic [1:0] TCM_EDGE_FALL = 2'h0;
  localparam logic [1:0] TCM_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCM_EDGE_LOW  = 2'h2; // start fall, capture rise
  localparam logic [1:0] TCM_EDGE_HIGH = 2'h3; // start rise, capture fall

  localparam logic [2:0] TCM_TRIG_SW   = 3'h0;
  localparam logic [2:0] TCM_TRIG_EDGE = 3'h1;
  localparam logic [2:0] TCM_TRIG_BOTH = 3'h2;

  localparam logic [2:0] TCM_MD_INTERVAL = 3'h0;
  localparam logic [2:0] TCM_MD_CAPTURE  = 3'h2;
  localparam logic [2:0] TCM_MD_EVENT    = 3'h3;
  localparam logic [2:0] TCM_MD_ONECOUNT = 3'h4;
  localparam logic [2:0] TCM_MD_CAPONE   = 3'h6;

  // control register bits (write one to act)
  localparam int TCM_CTRL_START = 0;
  localparam int TCM_CTRL_STOP  = 1;

  // status register bit positions
  localparam int TCM_ST_COUNT = 0;
  localparam int TCM_ST_UP    = 1;
  localparam int TCM_ST_LEGAL = 2;
  localparam int TCM_ST_PIN   = 3;

  // ***********************************************************
  // trigger outputs travel together
  // ***********************************************************
  typedef struct packed {
    logic reload;   // counter reinitialise and (re)start
    logic capture;  // capture the count
    logic irq;      // channel interrupt pulse
    logic toggle;   // channel output change
  } tcm_trig_t;

  localparam tcm_trig_t TCM_TRIG_IDLE = '{default: 1'b0};

endpackage : tcm_pkg

/* tcm_channel_asserts.sv */
// checker of tcm_channel port behaviour, with its bind
module tcm_channel_chk #(
  parameter int CHAN = 0
) (
  // clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  // register bus
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [tcm_pkg::TCM_ADDR_W-1:0] paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic                           pready,
  // pin and triggers
  input wire logic                           channel_input_pin,
  input tcm_pkg::tcm_trig_t                  trig,
  input wire logic                           count_up,
  input wire logic                           counting
);
  import tcm_pkg::*;
  // ****************
  // shadow and checks
  // ****************
  localparam int MA = 4 * (int'(TCM_MODE_IDX0) + 2 * CHAN);
  localparam int CA = 4 * (int'(TCM_CTRL_IDX0) + 2 * CHAN);
  logic [10:0] md_r;
  logic [2:0]  op;
  logic        pin;
  logic        sw_go;

  // shadow of the mode fields, taken at the same edge as the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_r <= 11'h000;
    end else if (psel && penable && pready && pwrite && paddr == 24'(MA)) begin
      md_r <= pwdata[10:0];
    end
  end
  assign op  = md_r[3:1];
  assign pin = channel_input_pin;
  // software start landing now; while counting it restarts in any mode without irq
  assign sw_go = psel && penable && pready && pwrite
                 && paddr == 24'(CA) && pwdata[0] && !pwdata[1];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY: assert property (psel && penable && !$past(penable)
    |=> pready) else $error("pready late");
  AST_UP_DIR: assert property (counting && $stable(md_r)
    |-> count_up == (op == TCM_MD_CAPTURE || op == TCM_MD_CAPONE))
    else $error("count direction wrong");
  AST_START_QUIET: assert property (trig.reload && !$past(counting)
    && (!md_r[0] || op[2]) |-> !trig.irq && !trig.toggle)
    else $error("start raised irq or toggle");
  AST_START_IRQ: assert property (trig.reload && !$past(counting)
    && md_r[0] && !op[2] && !op[0] |-> trig.irq && trig.toggle)
    else $error("start lacks irq or toggle");
  AST_NO_RETRIG: assert property ($past(counting) && !md_r[0] && op[2]
    && !$past(sw_go) |-> !trig.reload) else $error("retrigger accepted");
  AST_RETRIG_IRQ: assert property ($past(counting) && trig.reload
    && !$past(sw_go) && md_r[0] && op == TCM_MD_ONECOUNT |-> trig.irq)
    else $error("retrigger without irq");
  AST_SW_RESTART: assert property ($past(counting) && $past(sw_go)
    |-> trig.reload && !trig.irq) else $error("software restart wrong");
  AST_START_EDGE: assert property (!counting && op != TCM_MD_EVENT
    && md_r[10:8] == TCM_TRIG_EDGE && (md_r[6] ? $rose(pin) : $fell(pin))
    |-> ##[2:4] trig.reload) else $error("start edge missed");
  AST_CAP_EDGE: assert property (counting && op == TCM_MD_CAPTURE
    && md_r[10:8] == TCM_TRIG_EDGE && (md_r[7] ^ md_r[6] ? $rose(pin) : $fell(pin))
    |-> ##[2:4] trig.capture) else $error("capture edge missed");

  // main scenarios reached
  cover property (trig.reload && trig.irq && $past(counting));
  cover property (trig.capture);
  cover property (pready && pwrite);
endmodule // tcm_channel_chk

bind tcm_channel tcm_channel_chk #(.CHAN(CHAN)) tcm_channel_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .channel_input_pin(channel_input_pin), .trig(trig),
  .count_up(count_up), .counting(counting));

/* tcm_pin_src.sv */
// model of the signal source that drives the channel input pin
module tcm_pin_src (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // request from the bench
  input wire logic       go,
  input wire logic       lvl,
  input wire logic [3:0] dly,
  // timer input pin
  output logic           pin
);
  logic [3:0] cnt_r;
  logic       lvl_r;

  // level lands dly cycles after go, so prompt and slow sources occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      lvl_r <= 1'b0;
      pin   <= 1'b0;
    end else if (go) begin
      cnt_r <= dly;
      lvl_r <= lvl;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      pin   <= (cnt_r == 4'h1) ? lvl_r : pin;
    end
  end
endmodule // tcm_pin_src

/* tcm_channel_tb.sv */
// self-checking bench for tcm_channel with a pin source model
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %0h want %0h", $time, g, e); end end
module tcm_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  // ****************
  // bench
  // ****************
  localparam logic [23:0] MA = 24'(4 * int'(TCM_MODE_IDX0));
  localparam logic [23:0] CA = 24'(4 * int'(TCM_CTRL_IDX0));
  localparam logic [23:0] SA = 24'(4 * int'(TCM_STAT_IDX0));
  // legal mode nibbles only
  localparam logic [3:0] TAB [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin, go, lvl, master_irq, count_done, count_up, counting;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  dly;
  tcm_trig_t   trig;
  int          n_mismatch, num_checks, cyc, n_rel, n_irq, n_cap;

  tcm_channel #(.CHAN(0)) tcm_channel_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_input_pin(pin),
    .master_irq(master_irq), .count_done(count_done), .trig(trig),
    .count_up(count_up), .counting(counting));
  tcm_pin_src tcm_pin_src_i (.pclk(pclk), .presetn(presetn), .go(go),
    .lvl(lvl), .dly(dly), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // pulse tally and hang guard
  always @(posedge pclk) begin
    n_rel += int'(trig.reload);
    n_irq += int'(trig.irq);
    n_cap += int'(trig.capture);
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // channel 0 has no bit 11; bits 13, 5, 4 read zero
  function automatic logic [31:0] exp_rd(input logic [31:0] v);
    return {16'h0000, v[15:0] & 16'hd7cf};
  endfunction

  // totals over four pin edges: reload, irq, capture
  function automatic logic [4:0] exp_cnt(input logic [1:0] es,
    input logic [2:0] m, input logic b0);
    logic rt;
    rt = (m == TCM_MD_ONECOUNT) && b0;
    exp_cnt[4:3] = 2'h1 + 2'(rt) + 2'((m == TCM_MD_CAPONE) && es[1]);
    exp_cnt[2:1] = 2'(b0 && !m[2] && !m[0]) + 2'(rt);
    exp_cnt[0] = (m == TCM_MD_CAPTURE) || (m == TCM_MD_CAPONE);
  endfunction

  // request held until pready is seen at an edge
  task apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pin_to(input logic l);
    seed = lfsr(seed);
    lvl <= l;
    dly <= {1'b0, seed[2:0]} + 4'h1;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask

  // stop and park the mode first so the pin move starts nothing
  task setup(input logic [15:0] mw, input logic l);
    apb(1'b1, CA, 32'h2);
    apb(1'b1, MA, 32'h0);
    pin_to(l);
    apb(1'b1, MA, {16'h0000, mw});
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    int r0, i0, c0;
    logic [4:0] e;
    logic [1:0] e2;
    {psel, penable, pwrite, go, lvl, master_irq, count_done} = 7'h00;
    paddr = 24'h0;
    pwdata = 32'h0;
    dly = 4'h1;
    seed = 32'h05f70137;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MA, 32'h0);
    `CHK(rd, 32'h0)
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      apb(1'b1, MA, k == 0 ? 32'hffff_ffff : seed);
      apb(1'b0, MA, 32'h0);
      `CHK(rd, exp_rd(k == 0 ? 32'hffff_ffff : seed))
    end
    apb(1'b0, 24'h000100, 32'h0);
    `CHK(err, 1'b1)
    $display("register test done");
    for (int es = 0; es < 4; es++) begin
      for (int k = 0; k < 7; k++) begin
        e2 = 2'(es);
        setup({5'h0, TCM_TRIG_EDGE, e2, 2'h0, TAB[k]}, e2[0]);
        r0 = n_rel;
        i0 = n_irq;
        c0 = n_cap;
        pin_to(!e2[0]);
        `CHK(counting, 1'b0)
        pin_to(e2[0]);
        `CHK(counting, 1'b1)
        `CHK(count_up, TAB[k][2])
        pin_to(!e2[0]);
        pin_to(e2[0]);
        e = exp_cnt(e2, TAB[k][3:1], TAB[k][0]);
        `CHK(2'(n_rel - r0), e[4:3])
        `CHK(2'(n_irq - i0), e[2:1])
        `CHK(1'(n_cap - c0), e[0])
        `CHK(counting, !(TAB[k] == 4'hc && !e2[1]))
      end
    end
    $display("pin trigger test done");
    setup({5'h0, TCM_TRIG_SW, 4'h0, TCM_MD_EVENT, 1'b0}, 1'b0);
    r0 = n_rel;
    i0 = n_irq;
    apb(1'b1, CA, 32'h1);
    apb(1'b1, CA, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK(counting, 1'b1)
    `CHK(count_up, 1'b0)
    `CHK(2'(n_rel - r0), 2'h2)
    `CHK(2'(n_irq - i0), 2'h0)
    apb(1'b0, SA, 32'h0);
    `CHK(rd, (32'h1 << TCM_ST_COUNT) | (32'h1 << TCM_ST_LEGAL))
    $display("software start test done");
    // both pin edges start and capture, whatever the edge field says
    setup({5'h0, TCM_TRIG_BOTH, TCM_EDGE_LOW, 2'h0, TCM_MD_CAPTURE, 1'b0},
      1'b0);
    r0 = n_rel;
    c0 = n_cap;
    pin_to(1'b1);
    `CHK(2'(n_rel - r0), 2'h1)
    pin_to(1'b0);
    `CHK(1'(n_cap - c0), 1'b1)
    `CHK(counting, 1'b1)
    $display("both edge test done");
    setup({5'h0, 3'h4, 4'h0, TCM_MD_ONECOUNT, 1'b0}, 1'b0);
    master_irq <= 1'b1;
    @(posedge pclk);
    master_irq <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(counting, 1'b1)
    count_done <= 1'b1;
    @(posedge pclk);
    count_done <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(counting, 1'b0)
    $display("master trigger test done");
    stop_test();
  end
endmodule // tcm_channel_tb
